//--- design/cfda_core.sv
module cfda_core #(
  parameter logic [7:0] ACC_SPLIT = cfda_pkg::ACC_SPLIT_DEF
) (
  input  wire logic                    CLK,
  input  wire logic                    RESETN,
  input  wire cfda_pkg::cfda_apb_req_s APB_REQ,
  output      cfda_pkg::cfda_apb_rsp_s APB_RSP,
  output      cfda_pkg::cfda_pm_s      PM_OUT,
  input  wire logic [15:0]             PM_RDATA,
  output      cfda_pkg::cfda_dm_s      DM_OUT,
  input  wire logic [7:0]              DM_RDATA
);
  import cfda_pkg::*;

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    cfda_phase_e      phase;
    logic             run;
    logic [20:0]      pc;
    logic [15:0]      ir;
    logic             flush;
    logic             mvff;
    logic [7:0]       opnd;
    logic [7:0]       work;
    logic [3:0]       bank;
    logic [7:0]       hi_hold;
    logic [4:0]       up_hold;
    logic [20:0]      tptr;
    logic [7:0]       tlatch;
    logic [2:0][11:0] iptr;
    cfda_pm_s         pm;
    cfda_dm_s         dm;
    cfda_apb_rsp_s    apb;
  } cfda_state_s;

  cfda_state_s s_r;
  cfda_state_s s_nxt;

  logic        live;
  logic        is_lit;
  logic        is_add;
  logic        is_mov;
  logic        is_sto;
  logic        is_tst;
  logic        is_rmv;
  logic        is_jmp;
  logic        is_lip;
  logic        is_trd;
  logic        is_twr;
  logic        two_word;
  logic        rd_op;
  logic        wr_file;
  logic        wr_work;
  logic        pc_wr;
  logic        jump;
  logic [11:0] dir_adr;
  logic [11:0] src;
  logic [11:0] dst;
  logic [8:0]  sfr_rd;
  logic [7:0]  rdv;
  logic [7:0]  res;
  logic [20:0] pc_seq;
  logic        apb_done;
  logic [31:0] apb_data;
  logic        apb_hit;

  // ****************************************************
  // Address helpers
  // ****************************************************
  function automatic logic [11:0] f_dir(
    input logic [15:0] ins,
    input logic [3:0]  bs
  );
    if (ins[8]) begin
      f_dir = {bs, ins[7:0]};
    end else if (ins[7:0] < ACC_SPLIT) begin
      f_dir = {4'h0, ins[7:0]};
    end else begin
      f_dir = {4'hf, ins[7:0]};
    end
  endfunction

  function automatic logic [11:0] f_ind(
    input logic [11:0]      a,
    input logic [2:0][11:0] p
  );
    unique case (a)
      ADR_IACC0: f_ind = p[0];
      ADR_IACC1: f_ind = p[1];
      ADR_IACC2: f_ind = p[2];
      default:   f_ind = a;
    endcase
  endfunction

  function automatic logic [8:0] f_sfr(
    input logic [11:0] a,
    input cfda_state_s st
  );
    unique case (a)
      ADR_PC_LOW:     f_sfr = {1'b1, st.pc[7:0]};
      ADR_PC_HI_HOLD: f_sfr = {1'b1, st.hi_hold};
      ADR_PC_UP_HOLD: f_sfr = {4'h8, st.up_hold};
      ADR_TPTR_U:     f_sfr = {4'h8, st.tptr[20:16]};
      ADR_TPTR_H:     f_sfr = {1'b1, st.tptr[15:8]};
      ADR_TPTR_L:     f_sfr = {1'b1, st.tptr[7:0]};
      ADR_TLATCH:     f_sfr = {1'b1, st.tlatch};
      ADR_WORKING:    f_sfr = {1'b1, st.work};
      ADR_BANK_SEL:   f_sfr = {5'h10, st.bank};
      ADR_IPTR0_H:    f_sfr = {5'h10, st.iptr[0][11:8]};
      ADR_IPTR0_L:    f_sfr = {1'b1, st.iptr[0][7:0]};
      ADR_IPTR1_H:    f_sfr = {5'h10, st.iptr[1][11:8]};
      ADR_IPTR1_L:    f_sfr = {1'b1, st.iptr[1][7:0]};
      ADR_IPTR2_H:    f_sfr = {5'h10, st.iptr[2][11:8]};
      ADR_IPTR2_L:    f_sfr = {1'b1, st.iptr[2][7:0]};
      default:        f_sfr = 9'h000;
    endcase
  endfunction

  // ****************************************************
  // Decode and next state
  // ****************************************************
  always_comb begin
    live     = s_r.run && !s_r.flush;
    is_lit   = live && s_r.ir[15:8] == OPC_LOAD_LIT;
    is_add   = live && s_r.ir[15:10] == OPC_ADD_WORK;
    is_mov   = live && s_r.ir[15:10] == OPC_MOVE_FILE;
    is_sto   = live && s_r.ir[15:9] == OPC_STORE_WORK;
    is_tst   = live && s_r.ir[15:9] == OPC_TEST_SKIP;
    is_rmv   = live && s_r.ir[15:12] == OPC_REG_MOVE;
    is_jmp   = live && (s_r.ir[15:8] == OPC_ABS_JUMP ||
                        s_r.ir[15:9] == OPC_INVOKE);
    is_lip   = live && s_r.ir[15:6] == OPC_LOAD_IPTR;
    is_trd   = live && s_r.ir == OPC_TABLE_RD;
    is_twr   = live && s_r.ir == OPC_TABLE_WR;
    // Words led by the marker nibble decode as nothing
    two_word = is_rmv || is_jmp || is_lip;
    rd_op    = is_add || is_mov || is_tst || is_rmv;
    dir_adr  = f_dir(s_r.ir, s_r.bank);
    src      = is_rmv ? s_r.ir[11:0] : f_ind(dir_adr, s_r.iptr);
    dst      = s_r.mvff ? s_r.ir[11:0] : src;
    sfr_rd   = f_sfr(src, s_r);
    if (sfr_rd[8]) begin
      rdv = sfr_rd[7:0];
    end else if (src < GPR_TOP) begin
      rdv = DM_RDATA;
    end else begin
      rdv = 8'h00;
    end
    if (is_add) begin
      res = s_r.opnd + s_r.work;
    end else if (is_sto) begin
      res = s_r.work;
    end else begin
      res = s_r.opnd;
    end
    wr_file  = ((is_add || is_mov) && s_r.ir[9]) || is_sto ||
               (s_r.run && s_r.mvff);
    wr_work  = is_lit || ((is_add || is_mov) && !s_r.ir[9]);
    pc_wr    = wr_file && dst == ADR_PC_LOW;
    jump     = is_jmp || pc_wr;
    pc_seq   = s_r.pc + PC_STEP;
    apb_done = APB_REQ.psel && APB_REQ.penable && s_r.apb.pready;
    apb_hit  = 1'b1;
    unique case (APB_REQ.paddr)
      REG_CTRL: apb_data = {31'h0, s_r.run};
      REG_PC:   apb_data = {11'h0, s_r.pc};
      REG_CORE: apb_data = {12'h0, s_r.bank, s_r.tlatch, s_r.work};
      default: begin
        apb_data = 32'h0;
        apb_hit  = 1'b0;
      end
    endcase

    s_nxt = s_r;
    // Bus slave: one wait state, then a one-cycle ready
    s_nxt.apb.pready  = APB_REQ.psel && APB_REQ.penable &&
                        !s_r.apb.pready;
    s_nxt.apb.prdata  = 32'h0;
    s_nxt.apb.pslverr = 1'b0;
    if (s_nxt.apb.pready) begin
      s_nxt.apb.prdata  = APB_REQ.pwrite ? 32'h0 : apb_data;
      s_nxt.apb.pslverr = !apb_hit;
    end
    if (apb_done && APB_REQ.pwrite && APB_REQ.paddr == REG_CTRL) begin
      s_nxt.run = APB_REQ.pwdata[CTRL_RUN_BIT];
    end

    if (s_r.run) begin
      s_nxt.phase = cfda_phase_e'(s_r.phase + 2'h1);
      unique case (s_r.phase)
        PH_Q1: begin
          s_nxt.dm.addr = src;
          s_nxt.dm.re   = rd_op;
          if (is_trd || is_twr) begin
            s_nxt.pm.addr  = s_r.tptr;
            s_nxt.pm.we    = is_twr;
            s_nxt.pm.wdata = s_r.tlatch;
          end
        end
        PH_Q2: begin
          s_nxt.dm.re   = 1'b0;
          s_nxt.pm.addr = s_r.pc;
          s_nxt.pm.we   = 1'b0;
          if (rd_op) begin
            s_nxt.opnd = rdv;
          end
          if (rd_op && !is_add && src == ADR_PC_LOW) begin
            s_nxt.hi_hold = s_r.pc[15:8];
            s_nxt.up_hold = s_r.pc[20:16];
          end
          if (is_trd) begin
            s_nxt.tlatch = s_r.tptr[0] ? PM_RDATA[15:8] :
                                         PM_RDATA[7:0];
          end
        end
        PH_Q3: begin
          if (wr_file && dst < GPR_TOP) begin
            s_nxt.dm.addr  = dst;
            s_nxt.dm.we    = 1'b1;
            s_nxt.dm.wdata = res;
          end
        end
        PH_Q4: begin
          s_nxt.dm.we = 1'b0;
          if (wr_work) begin
            s_nxt.work = is_lit ? s_r.ir[7:0] : res;
          end
          if (wr_file) begin
            unique case (dst)
              ADR_PC_HI_HOLD: s_nxt.hi_hold = res;
              ADR_PC_UP_HOLD: s_nxt.up_hold = res[4:0];
              ADR_TPTR_U:     s_nxt.tptr[20:16] = res[4:0];
              ADR_TPTR_H:     s_nxt.tptr[15:8] = res;
              ADR_TPTR_L:     s_nxt.tptr[7:0] = res;
              ADR_TLATCH:     s_nxt.tlatch = res;
              ADR_WORKING:    s_nxt.work = res;
              ADR_BANK_SEL:   s_nxt.bank = res[3:0];
              ADR_IPTR0_H:    s_nxt.iptr[0][11:8] = res[3:0];
              ADR_IPTR0_L:    s_nxt.iptr[0][7:0] = res;
              ADR_IPTR1_H:    s_nxt.iptr[1][11:8] = res[3:0];
              ADR_IPTR1_L:    s_nxt.iptr[1][7:0] = res;
              ADR_IPTR2_H:    s_nxt.iptr[2][11:8] = res[3:0];
              ADR_IPTR2_L:    s_nxt.iptr[2][7:0] = res;
              default: begin
              end
            endcase
          end
          if (is_lip && s_r.ir[5:4] != 2'h3) begin
            s_nxt.iptr[s_r.ir[5:4]] = {s_r.ir[3:0],
                                       PM_RDATA[7:0]};
          end
          // Fetch completes; the prefetched word may be discarded
          s_nxt.ir    = PM_RDATA;
          s_nxt.flush = is_tst && s_r.opnd == 8'h00;
          s_nxt.mvff  = is_rmv;
          s_nxt.pc    = pc_seq;
          if (is_jmp) begin
            s_nxt.pc    = {PM_RDATA[11:0], s_r.ir[7:0], 1'b0};
            s_nxt.flush = 1'b1;
          end
          if (pc_wr) begin
            s_nxt.pc    = {s_r.up_hold, s_r.hi_hold,
                           res[7:1], 1'b0};
            s_nxt.flush = 1'b1;
          end
          s_nxt.pm.addr = s_nxt.pc;
        end
      endcase
    end

    // General registers live outside and are untouched here
    if (!RESETN) begin
      s_nxt       = '0;
      s_nxt.run   = CTRL_RUN_RST;
      s_nxt.flush = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    s_r <= s_nxt;
  end

  assign APB_RSP = s_r.apb;
  assign PM_OUT  = s_r.pm;
  assign DM_OUT  = s_r.dm;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  AST_PHASE_WRAP: assert property (
    s_r.run && s_r.phase == PH_Q4 && !apb_done |=> s_r.phase == PH_Q1)
    else $error("phase did not wrap to first quarter");

  AST_READ_Q2: assert property (
    DM_OUT.re |-> s_r.phase == PH_Q2 && $past(s_r.phase) == PH_Q1)
    else $error("data read outside second quarter");

  AST_WRITE_Q4: assert property (
    DM_OUT.we |-> s_r.phase == PH_Q4 && DM_OUT.addr < SFR_BASE)
    else $error("data write misplaced");

  AST_PC_EVEN: assert property (
    s_r.pc[0] == 1'b0)
    else $error("program counter odd");

  AST_SEQ_STEP: assert property (
    s_r.run && s_r.phase == PH_Q4 && !jump
    |=> s_r.pc == $past(s_r.pc) + PC_STEP && PM_OUT.addr == s_r.pc)
    else $error("sequential step not two");

  AST_JUMP_FLUSH: assert property (
    s_r.run && s_r.phase == PH_Q4 && jump
    |=> s_r.flush && !live)
    else $error("jump did not discard prefetch");

  AST_TARGET: assert property (
    s_r.phase == PH_Q4 && is_jmp && s_r.run
    |=> s_r.pc == {$past(PM_RDATA[11:0]), $past(s_r.ir[7:0]), 1'b0})
    else $error("jump target wrong");

  AST_HOLD_KEEP: assert property (
    s_r.run && s_r.phase == PH_Q2 && is_add
    |=> $stable(s_r.hi_hold) && $stable(s_r.up_hold))
    else $error("add refreshed holding latches");

  AST_APB_READY: assert property (
    APB_REQ.psel && APB_REQ.penable && !APB_RSP.pready
    |=> APB_RSP.pready ##1 !APB_RSP.pready)
    else $error("bus ready not one cycle");

  COV_JUMP: cover property (is_jmp && s_r.phase == PH_Q4);
  COV_MOVE: cover property (s_r.mvff && DM_OUT.we);
  COV_SKIP: cover property (is_tst ##4 s_r.flush);
  COV_TABLE: cover property (is_trd && s_r.phase == PH_Q2);

endmodule

//--- design/cfda_pkg.sv
// Overview of operation
// - Branches and two-word instructions take two cycles, others one
// - Exactly four two-word instructions are decoded
// - Second word has top four bits set
// - First word takes operand from second's low twelve bits, pointer load from its low eight
// - Lone second word executes as no-operation
// - Add to low byte performs computed jump
// - Program counter bit zero stays zero
// - Only non-add reads of low byte refresh holding latches
// - Two table bytes per program word
// - Data addresses are twelve bits wide
// - Sixteen banks, low select bits pick bank
// - Upper bank select bits are not implemented
// - Special registers at top, general from bottom
// - Unimplemented data locations read as zero
// - Indirect pointers hold full twelve-bit address
// - Register move copies across banks, two cycles
// - Access bank joins bank zero and fifteen
// - General registers are never cleared by reset
// - Bank fifteen special, banks zero to five general
// - Four phases; read phase two, write four
// - Low byte write loads upper bytes from latches
// - Counter is 21 bits and steps by two
package cfda_pkg;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } cfda_phase_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cfda_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } cfda_apb_rsp_s;

  typedef struct packed {
    logic [20:0] addr;
    logic        we;
    logic [7:0]  wdata;
  } cfda_pm_s;

  typedef struct packed {
    logic [11:0] addr;
    logic        re;
    logic        we;
    logic [7:0]  wdata;
  } cfda_dm_s;

  // ****************************************************
  // Data memory map
  // ****************************************************
  localparam logic [11:0] SFR_BASE       = 12'hf00;
  localparam logic [11:0] GPR_TOP        = 12'h600;
  localparam logic [7:0]  ACC_SPLIT_DEF  = 8'h60;
  localparam logic [11:0] ADR_PC_LOW     = 12'hff9;
  localparam logic [11:0] ADR_PC_HI_HOLD = 12'hffa;
  localparam logic [11:0] ADR_PC_UP_HOLD = 12'hffb;
  localparam logic [11:0] ADR_TPTR_U     = 12'hff8;
  localparam logic [11:0] ADR_TPTR_H     = 12'hff7;
  localparam logic [11:0] ADR_TPTR_L     = 12'hff6;
  localparam logic [11:0] ADR_TLATCH     = 12'hff5;
  localparam logic [11:0] ADR_IACC0      = 12'hfef;
  localparam logic [11:0] ADR_IPTR0_H    = 12'hfea;
  localparam logic [11:0] ADR_IPTR0_L    = 12'hfe9;
  localparam logic [11:0] ADR_WORKING    = 12'hfe8;
  localparam logic [11:0] ADR_IACC1      = 12'hfe7;
  localparam logic [11:0] ADR_IPTR1_H    = 12'hfe2;
  localparam logic [11:0] ADR_IPTR1_L    = 12'hfe1;
  localparam logic [11:0] ADR_BANK_SEL   = 12'hfe0;
  localparam logic [11:0] ADR_IACC2      = 12'hfdf;
  localparam logic [11:0] ADR_IPTR2_H    = 12'hfda;
  localparam logic [11:0] ADR_IPTR2_L    = 12'hfd9;

  // ****************************************************
  // Instruction encodings
  // ****************************************************
  localparam logic [7:0]  OPC_LOAD_LIT   = 8'h0e;
  localparam logic [5:0]  OPC_ADD_WORK   = 6'h09;
  localparam logic [5:0]  OPC_MOVE_FILE  = 6'h14;
  localparam logic [6:0]  OPC_STORE_WORK = 7'h37;
  localparam logic [6:0]  OPC_TEST_SKIP  = 7'h33;
  localparam logic [3:0]  OPC_REG_MOVE   = 4'hc;
  localparam logic [7:0]  OPC_ABS_JUMP   = 8'hef;
  localparam logic [6:0]  OPC_INVOKE     = 7'h76;
  localparam logic [9:0]  OPC_LOAD_IPTR  = 10'h3b8;
  localparam logic [15:0] OPC_TABLE_RD   = 16'h0008;
  localparam logic [15:0] OPC_TABLE_WR   = 16'h000c;
  localparam logic [3:0]  OPC_SECOND_WD  = 4'hf;
  localparam logic [20:0] PC_STEP        = 21'h000002;

  // ****************************************************
  // Bus registers
  // ****************************************************
  localparam logic [11:0] REG_CTRL       = 12'h000;
  localparam logic [11:0] REG_PC         = 12'h004;
  localparam logic [11:0] REG_CORE       = 12'h008;
  localparam int          CTRL_RUN_BIT   = 0;
  localparam logic        CTRL_RUN_RST   = 1'b0;

endpackage

//--- sim/cfda_mem_model.sv
// ****************************************
// Program memory and data RAM model
// ****************************************
module cfda_mem_model (
  input  wire logic               clk,
  input  wire cfda_pkg::cfda_pm_s pm,
  output      logic [15:0]        pm_rdata,
  input  wire cfda_pkg::cfda_dm_s dm,
  output      logic [7:0]         dm_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import cfda_pkg::*;

  logic [15:0] pm_mem [0:255];
  logic [7:0]  ram    [0:4095];
  logic [7:0]  idle_pat;

  // RAM starts with a non-zero pattern and is never cleared
  initial begin
    idle_pat = 8'h5a;
    for (int i = 0; i < 256; i++) begin
      pm_mem[i] = 16'hffff;
    end
    for (int i = 0; i < 4096; i++) begin
      ram[i] = 8'(i) ^ 8'ha5;
    end
  end

  always_comb pm_rdata = pm_mem[pm.addr[8:1]];
  // Outside a read the data lines toggle every cycle
  always_comb dm_rdata = dm.re ? ram[dm.addr] : idle_pat;

  always @(posedge clk) begin
    idle_pat <= ~idle_pat;
    if (dm.we) begin
      ram[dm.addr] <= dm.wdata;
    end
    if (pm.we && pm.addr[0]) begin
      pm_mem[pm.addr[8:1]][15:8] <= pm.wdata;
    end
    if (pm.we && !pm.addr[0]) begin
      pm_mem[pm.addr[8:1]][7:0] <= pm.wdata;
    end
  end
endmodule

//--- sim/tb_core_fetch_and_data_addressing.sv
module tb_core_fetch_and_data_addressing;
  timeunit 1ns;
  timeprecision 1ps;
  import cfda_pkg::*;

  logic          clk;
  logic          resetn;
  cfda_apb_req_s apb_req;
  cfda_apb_rsp_s apb_rsp;
  cfda_pm_s      pm_out;
  cfda_dm_s      dm_out;
  logic [15:0]   pm_rdata;
  logic [7:0]    dm_rdata;
  int            n_fail;
  int            n_tests;
  int            n;
  logic [19:0]   exp_q[$];
  logic [20:0]   pa;
  logic [7:0]    rnd;
  logic [31:0]   rd;
  logic          err;

  cfda_core #(.ACC_SPLIT(ACC_SPLIT_DEF)) uut (
    .CLK      (clk),
    .RESETN   (resetn),
    .APB_REQ  (apb_req),
    .APB_RSP  (apb_rsp),
    .PM_OUT   (pm_out),
    .PM_RDATA (pm_rdata),
    .DM_OUT   (dm_out),
    .DM_RDATA (dm_rdata)
  );

  cfda_mem_model mem (
    .clk           (clk),
    .pm            (pm_out),
    .pm_rdata      (pm_rdata),
    .dm            (dm_out),
    .dm_rdata      (dm_rdata)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(string what, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int k;
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= wr;
    apb_req.paddr   <= a;
    apb_req.pwdata  <= wd;
    @(posedge clk);
    apb_req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (apb_rsp.pready !== 1'b1 && k < 50);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
    check("pready", 32'h1, 32'(apb_rsp.pready === 1'b1));
    @(posedge clk);
  endtask

  task automatic p(input logic [15:0] w);
    mem.pm_mem[pa[8:1]] = w;
    pa = pa + PC_STEP;
  endtask

  task automatic ex(input logic [11:0] a, input logic [7:0] d);
    exp_q.push_back({a, d});
  endtask

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Every data write is compared with the expected sequence
  always @(posedge clk) begin
    if (dm_out.we === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("dm write extra", 32'hffffffff, {dm_out.addr, dm_out.wdata});
      end else begin
        check("dm write", exp_q.pop_front(), {dm_out.addr, dm_out.wdata});
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("MISMATCH watchdog expected done seen timeout");
    final_report;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    apb_req = '0;
    resetn = 1'b0;
    pa = '0;
    n_fail = 0;
    n_tests = 0;
    rnd = 8'($urandom(97912));
    rnd = 8'($urandom_range(255, 0));
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    apb(1'b0, REG_CTRL, 32'h0);
    check("ctrl reset", 32'h0, rd);
    apb(1'b1, REG_PC, 32'hffffffff);
    apb(1'b0, REG_PC, 32'h0);
    check("pc read only", 32'h0, rd);
    apb(1'b0, {10'($urandom_range(1023, 3)), 2'b00}, 32'h0);
    check("unmapped err", 32'h1, 32'(err));
    check("unmapped data", 32'h0, rd);
    $display("Test registers done");

    p({OPC_LOAD_LIT, rnd});
    p(16'h6e10); ex(12'h010, rnd);
    p(16'hc010); p(16'hf456); ex(12'h456, rnd);
    p(16'hef08); p(16'hf000);
    p(16'h6e50); p(16'h6e51);
    p(16'h0ef3); p(16'h6ee0);
    p(16'h6f20); ex(12'h320, 8'hf3);
    p(16'hee01); p(16'hf023); p(16'h6eef); ex(12'h123, 8'hf3);
    p(16'h0e00); p(16'h6e41); ex(12'h041, 8'h00);
    p(16'h6641); p(16'hc010); p(16'hf456);
    p(16'h6e42); ex(12'h042, 8'h00);
    p(16'hc700); p(16'hf043); ex(12'h043, 8'h00);
    p(16'h0e04); p(16'h26f9); p(16'h6e52); p(16'h6e53);
    p(16'h6e54); ex(12'h054, 8'h04);
    p(16'h0e81); p(16'h6ef6); p(OPC_TABLE_RD);
    p(16'h0e84); p(16'h6ef6); p(OPC_TABLE_WR);
    p({8'hec, pa[8:1]}); p(16'hf000);
    mem.pm_mem[8'h40] = 16'h3cc3;
    mem.pm_mem[8'h42] = 16'h1111;
    apb(1'b1, REG_CTRL, 32'h1);
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    repeat (100) @(posedge clk);
    check("pending writes", 32'h0, 32'(exp_q.size()));
    apb(1'b0, REG_CORE, 32'h0);
    check("core state", 32'h00033c84, rd);
    check("table write", 32'h113c, 32'(mem.pm_mem[8'h42]));
    $display("Test program done");

    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    apb(1'b0, REG_CTRL, 32'h0);
    check("ctrl after reset", 32'h0, rd);
    apb(1'b0, REG_PC, 32'h0);
    check("pc after reset", 32'h0, rd);
    repeat (50) @(posedge clk);
    $display("Test second reset done");
    final_report;
  end
endmodule
